// file: rtl/wpcg_clock_control.sv
// Warm-up timer, clock multiplier selection, clock gear and prescaler control
`timescale 1ns/1ps
`default_nettype none
`include "wpcg_map.svh"

// Overview of operation
// RQ1: Warm-up counter counts oscillator ticks or external ticks, chosen by warm-up clock select.
// RQ2: Duration field is 12 bits; the counter compares against it times sixteen.
// RQ3: Writing one to the warm-up start bit restarts the counter from zero.
// RQ4: Busy flag reads one during warm-up and zero once the duration elapses.
// RQ5: A new duration shows in readback only after a delay; software polls it.
// RQ6: Warm-up timer advances on oscillator ticks, so its time is approximate.
// RQ7: Leaving deep stop resets source, enables and select bits; duration is kept.
// RQ8: Multiplied clock runs at twice the oscillator rate.
// RQ9: After reset multiplier enable and select are clear; high-speed clock equals oscillator.
// RQ10: Software sets the multiplier value while disabled, then waits before enabling.
// RQ11: Software waits for lock after enabling before selecting the multiplied clock.
// RQ12: Only the single permitted times-two multiplier value may be written.
// RQ13: Software never uses multiplication while the internal oscillator feeds the system.
// RQ14: System clock divides by the gear setting; changes apply after a short delay.
// RQ15: Prescaler input divides the peripheral clock; undivided after reset.
// RQ16: Software leaves the gear alone while timers or peripherals run.
// RQ17: After reset the internal oscillator runs; external oscillator and multiplier unused.
// RQ18: Idle and deep stop both halt the processor core.
// RQ19: Gear offers exactly undivided, half, quarter, eighth and sixteenth.
// RQ20: Prescaler offers undivided, or divided by 2, 4, 8, 16 or 32.
// RQ21: Read-only status bit shows oscillator (zero) or multiplied clock (one).
// RQ22: Start clears counter and sets busy; busy clears when upper bits match.
module wpcg_clock_control (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`WPCG_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic ext_warmup_tick,
	input wire logic sleep_request,
	input wire logic wake_request,
	output var wpcg_pkg::wpcg_osc_t osc_ctrl,
	output logic multiplied_clock_active,
	output var wpcg_pkg::wpcg_clk_en_t clk_en,
	output logic core_halt,
	output logic deep_stop_mode
);

	// Decoded register accesses
	logic wr_osc;
	logic wr_mul;
	logic wr_sys;
	logic wr_stby;
	assign wr_osc = reg_write && (reg_addr == `WPCG_OSC_CTRL_ADDR);
	assign wr_mul = reg_write && (reg_addr == `WPCG_MUL_SEL_ADDR);
	assign wr_sys = reg_write && (reg_addr == `WPCG_SYS_CFG_ADDR);
	assign wr_stby = reg_write && (reg_addr == `WPCG_STANDBY_ADDR);

	wpcg_pkg::wpcg_state_t state;
	wpcg_pkg::wpcg_sys_cfg_t sys_cfg;
	logic [2:0] standby_mode;
	logic multiplier_clock_select;
	logic [14:0] multiplier_setting;
	logic stop_exit;
	assign stop_exit = (state == wpcg_pkg::WPCG_DEEP_STOP) && wake_request;

	// Oscillator control fields; deep stop exit restores the internal oscillator
	always_ff @(posedge clk) begin
		if (!rst_n || stop_exit) begin
			osc_ctrl <= '0; // [RQ7] [RQ9] [RQ17]
		end else if (wr_osc) begin
			osc_ctrl.multiplier_enable <= reg_wdata[`WPCG_OSC_MUL_EN_BIT];
			osc_ctrl.warmup_clock_select <= reg_wdata[`WPCG_OSC_WUP_SEL_BIT];
			osc_ctrl.oscillator_source_select <= reg_wdata[`WPCG_OSC_SRC_BIT];
			osc_ctrl.external_oscillator_enable_b <= reg_wdata[`WPCG_OSC_EXT_B_BIT];
			osc_ctrl.external_oscillator_enable_a <= reg_wdata[`WPCG_OSC_EXT_A_BIT];
		end
	end

	// Multiplier select and multiplier value
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			multiplier_clock_select <= 1'b0; // [RQ9]
			multiplier_setting <= `WPCG_MUL_SET_RESET;
		end else if (stop_exit) begin
			multiplier_clock_select <= 1'b0; // [RQ7]
		end else if (wr_mul) begin
			multiplier_clock_select <= reg_wdata[`WPCG_MUL_SEL_BIT];
			multiplier_setting <= reg_wdata[`WPCG_MUL_SET_MSB:`WPCG_MUL_SET_LSB];
		end
	end

	// Gear, peripheral select, prescaler select and standby mode
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sys_cfg.gear_select <= `WPCG_GEAR_RESET;
			sys_cfg.peripheral_clock_select <= 1'b0;
			sys_cfg.prescaler_divider_select <= `WPCG_PRESC_RESET; // [RQ15]
			standby_mode <= `WPCG_STBY_RESET;
		end else begin
			if (wr_sys) begin
				sys_cfg.gear_select <= reg_wdata[`WPCG_SYS_GEAR_MSB:`WPCG_SYS_GEAR_LSB];
				sys_cfg.peripheral_clock_select <= reg_wdata[`WPCG_SYS_PERIPH_SEL_BIT];
				sys_cfg.prescaler_divider_select <= reg_wdata[`WPCG_SYS_PRESC_MSB:`WPCG_SYS_PRESC_LSB];
			end
			if (wr_stby) begin
				standby_mode <= reg_wdata[`WPCG_STBY_MSB:`WPCG_STBY_LSB];
			end
		end
	end

	// Duration request and its delayed effective copy; reset only, never at stop exit
	logic [11:0] warmup_duration_req;
	logic [11:0] warmup_duration_value;
	logic [2:0] dur_sync_cnt;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			warmup_duration_req <= `WPCG_DUR_RESET;
			warmup_duration_value <= `WPCG_DUR_RESET;
			dur_sync_cnt <= 3'h0;
		end else if (wr_osc) begin
			warmup_duration_req <= reg_wdata[`WPCG_OSC_DUR_MSB:`WPCG_OSC_DUR_LSB];
			dur_sync_cnt <= `WPCG_DUR_SYNC_CYCLES; // [RQ5]
		end else if (dur_sync_cnt != 3'h0) begin
			dur_sync_cnt <= dur_sync_cnt - 3'h1;
			if (dur_sync_cnt == 3'h1) begin
				warmup_duration_value <= warmup_duration_req; // [RQ5] [RQ7]
			end
		end
	end

	// External warm-up tick: three stages, a rise counts once stages two and three agree
	logic ext_s1;
	logic ext_s2;
	logic ext_s3;
	logic ext_level;
	logic ext_tick;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			ext_level <= 1'b0;
			ext_tick <= 1'b0;
		end else begin
			ext_s1 <= ext_warmup_tick;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			if (ext_s2 == ext_s3) begin
				ext_level <= ext_s3;
			end
			ext_tick <= (ext_s2 == ext_s3) && ext_s3 && !ext_level;
		end
	end

	// Oscillator tick at half the clk rate; clk stands for the multiplied rate
	logic osc_tick;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			osc_tick <= 1'b0;
		end else begin
			osc_tick <= !osc_tick;
		end
	end

	// Warm-up counter and busy flag
	logic [15:0] warmup_cnt;
	logic warmup_busy_flag;
	logic warmup_start;
	logic warmup_step;
	logic warmup_hit;
	assign warmup_start = wr_osc && reg_wdata[`WPCG_OSC_START_BIT];
	assign warmup_step = osc_ctrl.warmup_clock_select ? ext_tick : osc_tick; // [RQ1] [RQ6]
	assign warmup_hit = (warmup_cnt[15:4] == warmup_duration_value); // [RQ2]
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			warmup_cnt <= 16'h0000;
			warmup_busy_flag <= 1'b0;
		end else if (warmup_start) begin
			warmup_cnt <= 16'h0000; // [RQ3] [RQ22]
			warmup_busy_flag <= 1'b1; // [RQ4] [RQ22]
		end else if (warmup_busy_flag) begin
			if (warmup_hit) begin
				warmup_busy_flag <= 1'b0; // [RQ4] [RQ22]
			end else if (warmup_step) begin
				warmup_cnt <= warmup_cnt + 16'h0001; // [RQ3]
			end
		end
	end

	// Switch the high-speed source only on an oscillator tick boundary
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			multiplied_clock_active <= 1'b0; // [RQ9]
		end else if (osc_tick) begin
			multiplied_clock_active <= multiplier_clock_select && osc_ctrl.multiplier_enable; // [RQ21]
		end
	end

	// Core state: idle or deep stop entered on sleep, left on wake
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= wpcg_pkg::WPCG_NORMAL;
		end else begin
			unique case (state)
				wpcg_pkg::WPCG_NORMAL: begin
					if (sleep_request && standby_mode == `WPCG_STBY_IDLE) begin
						state <= wpcg_pkg::WPCG_IDLE;
					end else if (sleep_request && standby_mode == `WPCG_STBY_DEEP_STOP) begin
						state <= wpcg_pkg::WPCG_DEEP_STOP;
					end
				end
				wpcg_pkg::WPCG_IDLE, wpcg_pkg::WPCG_DEEP_STOP: begin
					if (wake_request) begin
						state <= wpcg_pkg::WPCG_NORMAL;
					end
				end
			endcase
		end
	end

	// Halt indications follow the state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			core_halt <= 1'b0;
			deep_stop_mode <= 1'b0;
		end else begin
			core_halt <= (state != wpcg_pkg::WPCG_NORMAL); // [RQ18]
			deep_stop_mode <= (state == wpcg_pkg::WPCG_DEEP_STOP);
		end
	end

	// Divider mask for a gear code; codes above sixteenth act as undivided
	function automatic logic [3:0] gear_mask(input logic [2:0] code);
		logic [3:0] m;
		m = 4'h0;
		unique case (code)
			`WPCG_GEAR_DIV2: m = 4'h1;
			`WPCG_GEAR_DIV4: m = 4'h3;
			`WPCG_GEAR_DIV8: m = 4'h7;
			`WPCG_GEAR_DIV16: m = 4'hf;
			default: m = 4'h0;
		endcase
		return m;
	endfunction : gear_mask

	// High-speed tick outside deep stop: every clk with the multiplier, every other one without
	logic run;
	logic fc_tick;
	assign run = (state != wpcg_pkg::WPCG_DEEP_STOP);
	assign fc_tick = run && (multiplied_clock_active || osc_tick); // [RQ8]

	// Gear divider; a new gear waits for the sixteen-tick boundary
	logic [3:0] gear_cnt;
	logic [2:0] active_gear;
	logic gear_tick;
	assign gear_tick = fc_tick && ((gear_cnt & gear_mask(active_gear)) == 4'h0); // [RQ14] [RQ19]
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gear_cnt <= 4'h0;
			active_gear <= `WPCG_GEAR_RESET;
		end else if (fc_tick) begin
			gear_cnt <= gear_cnt + 4'h1;
			if (gear_cnt == 4'hf) begin
				active_gear <= sys_cfg.gear_select; // [RQ14]
			end
		end
	end

	// Prescaler on the peripheral clock, divide by two to the code; codes above divide by 32 run undivided
	logic periph_tick;
	logic [4:0] pre_cnt;
	logic [4:0] pre_mask;
	logic pre_tick;
	assign periph_tick = sys_cfg.peripheral_clock_select ? fc_tick : gear_tick;
	assign pre_tick = periph_tick && ((pre_cnt & pre_mask) == 5'h00); // [RQ15] [RQ20]
	always_comb begin
		pre_mask = 5'h00;
		if (sys_cfg.prescaler_divider_select <= `WPCG_PRESC_DIV32) begin
			pre_mask = 5'(6'h01 << sys_cfg.prescaler_divider_select) - 5'h01; // [RQ20]
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pre_cnt <= 5'h00;
		end else if (periph_tick) begin
			pre_cnt <= pre_cnt + 5'h01;
		end
	end

	// Registered clock enables
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clk_en <= '0;
		end else begin
			clk_en.high_speed <= fc_tick;
			clk_en.system <= gear_tick;
			clk_en.peripheral <= periph_tick;
			clk_en.prescaler_input_clock <= pre_tick;
		end
	end

	// Read data one cycle after the read strobe; unmapped reads return zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			reg_rdata <= 32'h00000000;
			unique case (reg_addr)
				`WPCG_OSC_CTRL_ADDR: begin
					reg_rdata[`WPCG_OSC_BUSY_BIT] <= warmup_busy_flag; // [RQ4]
					reg_rdata[`WPCG_OSC_EXT_A_BIT] <= osc_ctrl.external_oscillator_enable_a;
					reg_rdata[`WPCG_OSC_EXT_B_BIT] <= osc_ctrl.external_oscillator_enable_b;
					reg_rdata[`WPCG_OSC_SRC_BIT] <= osc_ctrl.oscillator_source_select;
					reg_rdata[`WPCG_OSC_WUP_SEL_BIT] <= osc_ctrl.warmup_clock_select;
					reg_rdata[`WPCG_OSC_MUL_EN_BIT] <= osc_ctrl.multiplier_enable;
					reg_rdata[`WPCG_OSC_DUR_MSB:`WPCG_OSC_DUR_LSB] <= warmup_duration_value; // [RQ5]
				end
				`WPCG_MUL_SEL_ADDR: begin
					reg_rdata[`WPCG_MUL_SEL_BIT] <= multiplier_clock_select;
					reg_rdata[`WPCG_MUL_SET_MSB:`WPCG_MUL_SET_LSB] <= multiplier_setting;
					reg_rdata[`WPCG_MUL_STAT_BIT] <= multiplied_clock_active; // [RQ21]
				end
				`WPCG_SYS_CFG_ADDR: begin
					reg_rdata[`WPCG_SYS_GEAR_MSB:`WPCG_SYS_GEAR_LSB] <= sys_cfg.gear_select;
					reg_rdata[`WPCG_SYS_PERIPH_SEL_BIT] <= sys_cfg.peripheral_clock_select;
					reg_rdata[`WPCG_SYS_PRESC_MSB:`WPCG_SYS_PRESC_LSB] <= sys_cfg.prescaler_divider_select;
				end
				`WPCG_STANDBY_ADDR: begin
					reg_rdata[`WPCG_STBY_MSB:`WPCG_STBY_LSB] <= standby_mode;
				end
				default: reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_dur_write;
		wr_osc ##1 (!wr_osc) [*5];
	endsequence
	sequence s_warmup_done;
		warmup_busy_flag && warmup_hit && !warmup_start;
	endsequence
	a_warmup_start_busy: assert property (warmup_start |=> warmup_busy_flag && warmup_cnt == 16'h0000) // [RQ3]
		else $error("warm-up start did not clear counter and set busy");
	a_warmup_done_clear: assert property (s_warmup_done |=> !warmup_busy_flag) // [RQ4]
		else $error("busy flag did not clear at programmed duration");
	a_warmup_idle_hold: assert property (!warmup_busy_flag && !warmup_start |=> $stable(warmup_cnt)) // [RQ22]
		else $error("warm-up counter moved while idle");
	a_duration_reflect: assert property (s_dur_write |-> warmup_duration_value == warmup_duration_req) // [RQ5]
		else $error("duration readback not updated after delay");
	a_stop_exit_reinit: assert property (stop_exit |=> osc_ctrl == '0 && !multiplier_clock_select) // [RQ7]
		else $error("deep stop exit left oscillator fields set");
	a_multiplier_double: assert property (run && multiplied_clock_active |=> clk_en.high_speed) // [RQ8]
		else $error("multiplied clock missed a tick");
	a_gear_undivided: assert property (fc_tick && active_gear == `WPCG_GEAR_DIV1 |=> clk_en.system) // [RQ14]
		else $error("undivided gear did not pass a tick");
	a_prescaler_undivided: assert property ( // [RQ15]
		periph_tick && sys_cfg.prescaler_divider_select == `WPCG_PRESC_RESET |=> clk_en.prescaler_input_clock)
		else $error("undivided prescaler did not pass a tick");
	a_status_readback: assert property (reg_read && reg_addr == `WPCG_MUL_SEL_ADDR // [RQ21]
		|=> reg_rdata[`WPCG_MUL_STAT_BIT] == $past(multiplied_clock_active))
		else $error("multiplier status readback wrong");
	a_core_halted: assert property (state != wpcg_pkg::WPCG_NORMAL |=> core_halt) // [RQ18]
		else $error("core not halted in low power mode");

endmodule : wpcg_clock_control
`default_nettype wire

// file: rtl/wpcg_map.svh
// Register offsets, field positions, reset values and timing counts of the clock control block
`ifndef WPCG_MAP_SVH
`define WPCG_MAP_SVH

// Register word offsets (byte addresses)
`define WPCG_ADDR_W 8
`define WPCG_OSC_CTRL_ADDR 8'h00
`define WPCG_MUL_SEL_ADDR 8'h04
`define WPCG_SYS_CFG_ADDR 8'h08
`define WPCG_STANDBY_ADDR 8'h0c

// Oscillator control register fields
`define WPCG_OSC_START_BIT 0
`define WPCG_OSC_BUSY_BIT 1
`define WPCG_OSC_EXT_A_BIT 2
`define WPCG_OSC_EXT_B_BIT 3
`define WPCG_OSC_SRC_BIT 4
`define WPCG_OSC_WUP_SEL_BIT 5
`define WPCG_OSC_MUL_EN_BIT 6
`define WPCG_OSC_DUR_LSB 8
`define WPCG_OSC_DUR_MSB 19

// Multiplier select register fields
`define WPCG_MUL_SEL_BIT 0
`define WPCG_MUL_SET_LSB 1
`define WPCG_MUL_SET_MSB 15
`define WPCG_MUL_STAT_BIT 18

// System clock configuration register fields
`define WPCG_SYS_GEAR_LSB 0
`define WPCG_SYS_GEAR_MSB 2
`define WPCG_SYS_PERIPH_SEL_BIT 8
`define WPCG_SYS_PRESC_LSB 12
`define WPCG_SYS_PRESC_MSB 14

// Standby register fields and mode codes
`define WPCG_STBY_LSB 0
`define WPCG_STBY_MSB 2
`define WPCG_STBY_DEEP_STOP 3'h1
`define WPCG_STBY_IDLE 3'h3

// Gear codes: undivided, 1/2, 1/4, 1/8, 1/16
`define WPCG_GEAR_DIV1 3'h0
`define WPCG_GEAR_DIV2 3'h1
`define WPCG_GEAR_DIV4 3'h2
`define WPCG_GEAR_DIV8 3'h3
`define WPCG_GEAR_DIV16 3'h4

// Largest prescaler code: divide by 32
`define WPCG_PRESC_DIV32 3'h5

// Reset values
`define WPCG_DUR_RESET 12'h000
`define WPCG_MUL_SET_RESET 15'h0000
`define WPCG_GEAR_RESET 3'h0
`define WPCG_PRESC_RESET 3'h0
`define WPCG_STBY_RESET 3'h3

// Cycles from a duration write until the readback shows it
`define WPCG_DUR_SYNC_CYCLES 3'h4

`endif

// file: rtl/wpcg_pkg.sv
// Types shared by the clock control block
`default_nettype none
package wpcg_pkg;

	// Operating state of the processor core
	typedef enum logic [1:0] {
		WPCG_NORMAL,
		WPCG_IDLE,
		WPCG_DEEP_STOP
	} wpcg_state_t;

	// Oscillator control fields that software writes
	typedef struct packed {
		logic multiplier_enable;
		logic warmup_clock_select;
		logic oscillator_source_select;
		logic external_oscillator_enable_b;
		logic external_oscillator_enable_a;
	} wpcg_osc_t;

	// System clock configuration fields
	typedef struct packed {
		logic [2:0] prescaler_divider_select;
		logic peripheral_clock_select;
		logic [2:0] gear_select;
	} wpcg_sys_cfg_t;

	// One-cycle clock enable pulses handed to the rest of the chip
	typedef struct packed {
		logic high_speed;
		logic system;
		logic peripheral;
		logic prescaler_input_clock;
	} wpcg_clk_en_t;

endpackage : wpcg_pkg
`default_nettype wire

// file: verification/tb_warmup_pll_clock_gear_control.sv
// Self-checking bench for the warm-up, multiplier and gear control block
`timescale 1ns/1ps
`default_nettype none
module tb_warmup_pll_clock_gear_control;
	logic clk, rst_n, reg_write, reg_read, sleep_request, wake_request, ext_run;
	logic ext_warmup_tick, multiplied_clock_active, core_halt, deep_stop_mode;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, q;
	logic [3:0] half_period, ce;
	wpcg_pkg::wpcg_osc_t osc_ctrl;
	wpcg_pkg::wpcg_clk_en_t clk_en;
	int n_errors, comparisons, cyc, seed, dur, t0, k, c, hp;
	assign ce = clk_en;

	wpcg_clock_control wpcg_clock_control_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.ext_warmup_tick(ext_warmup_tick), .sleep_request(sleep_request), .wake_request(wake_request),
		.osc_ctrl(osc_ctrl), .multiplied_clock_active(multiplied_clock_active), .clk_en(clk_en),
		.core_halt(core_halt), .deep_stop_mode(deep_stop_mode));
	wpcg_osc_model wpcg_osc_model_inst (.clk(clk), .run(ext_run), .half_period(half_period),
		.tick(ext_warmup_tick));

	// Compare one value and count the result
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Register write: one cycle strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr

	// Register read: data stands in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		q = reg_rdata;
	endtask : rd

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_cyc

	// Count pulses of one clock enable over a window
	task automatic count_en(input int bi, input int n);
		c = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (ce[bi] === 1'b1) c++;
		end
	endtask : count_en

	// Oscillator control word: duration in [19:8], control bits in [6:0]
	function automatic logic [31:0] osc_word(input int d, input logic [6:0] f);
		return {12'h000, d[11:0], 1'b0, f};
	endfunction : osc_word

	// Write a duration and poll until the readback shows it
	task automatic set_dur(input int d, input logic [6:0] f);
		wr(8'h00, osc_word(d, f));
		for (k = 0; k < 12; k++) begin
			rd(8'h00);
			if (q[19:8] === d[11:0]) break;
		end
		check("duration_readback", {20'h0, q[19:8]}, d);
	endtask : set_dur

	// Poll the busy flag until it drops, bounded
	task automatic wait_idle(input int lim);
		for (k = 0; k < lim; k++) begin
			rd(8'h00);
			if (q[1] === 1'b0) break;
		end
	endtask : wait_idle

	task automatic end_of_test();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	// Clock at 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Cycle counter and hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			end_of_test();
		end
	end

	// Main sequence
	initial begin
		{rst_n, reg_write, reg_read, sleep_request, wake_request, ext_run} <= 6'h00;
		reg_addr <= 8'h00;
		reg_wdata <= 32'h0;
		half_period <= 4'h2;
		seed = 94;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values and unmapped places
		rd(8'h00);
		check("osc_reset", q, 32'h0);
		rd(8'h04);
		check("mul_reset", q, 32'h0);
		wr(8'h14, 32'hffffffff);
		rd(8'h08);
		check("sys_reset", q, 32'h0);
		rd(8'h0c);
		check("stby_reset", q, 32'h3);
		rd(8'h10);
		check("unmapped", q, 32'h0);
		check("mca_reset", {31'h0, multiplied_clock_active}, 32'h0);
		count_en(3, 20);
		check("fc_is_osc", c, 10);
		count_en(0, 20);
		check("presc_undiv", c, 10);
		// Warm-up on oscillator ticks with a random duration
		dur = 1 + ($unsigned($random(seed)) % 3);
		wr(8'h00, osc_word(dur, 7'h00));
		rd(8'h00);
		check("dur_delayed", {20'h0, q[19:8]}, 32'h0);
		set_dur(dur, 7'h00);
		wr(8'h00, osc_word(dur, 7'h01));
		t0 = cyc;
		rd(8'h00);
		check("busy_set", {31'h0, q[1]}, 32'h1);
		wait_idle(100);
		check("wup_time", 32'((cyc - t0) >= 32 * dur - 2 && (cyc - t0) <= 32 * dur + 10), 32'h1);
		check("start_reads_0", {31'h0, q[0]}, 32'h0);
		// Warm-up on the external pin: stalled source, then running
		dur = 1 + ($unsigned($random(seed)) % 2);
		hp = 2 + ($unsigned($random(seed)) % 3);
		half_period <= hp[3:0];
		set_dur(dur, 7'h20);
		wr(8'h00, osc_word(dur, 7'h21));
		wait_cyc(60);
		rd(8'h00);
		check("ext_stalled", {31'h0, q[1]}, 32'h1);
		ext_run <= 1'b1;
		t0 = cyc;
		wait_idle(200);
		check("ext_time", 32'((cyc - t0) >= 32 * dur * hp - 2 * hp && (cyc - t0) <= 32 * dur * hp + 20), 32'h1);
		ext_run <= 1'b0;
		// Multiplier bring-up in order, on the external source
		wr(8'h00, osc_word(dur, 7'h14));
		wr(8'h04, {16'h0, 15'h609f, 1'b0});
		wait_cyc(2500);
		wr(8'h00, osc_word(dur, 7'h54));
		wait_cyc(2500);
		check("mca_enable_only", {31'h0, multiplied_clock_active}, 32'h0);
		wr(8'h04, {16'h0, 15'h609f, 1'b1});
		wait_cyc(3);
		check("mca_on", {31'h0, multiplied_clock_active}, 32'h1);
		rd(8'h04);
		check("mul_status", q, {13'h0, 1'b1, 2'h0, 15'h609f, 1'b1});
		count_en(3, 20);
		check("fc_doubled", c, 20);
		// Every gear code on the doubled clock
		// Codes above sixteenth run undivided; peripheral follows the system clock
		for (int g = 0; g < 6; g++) begin
			wr(8'h08, {29'h0, 3'(g)});
			wait_cyc(40);
			count_en(2, 64);
			check("gear", c, (g < 5) ? (64 >> g) : 64);
			count_en(1, 64);
			check("periph_gear", c, (g < 5) ? (64 >> g) : 64);
		end
		// Every prescaler code, peripheral clock taken undivided
		for (int p = 0; p < 6; p++) begin
			wr(8'h08, {17'h0, 3'(p), 3'h0, 1'b1, 8'h00});
			wait_cyc(80);
			count_en(0, 128);
			check("presc", c, 128 >> p);
		end
		// Idle mode
		wr(8'h0c, 32'h3);
		@(posedge clk);
		sleep_request <= 1'b1;
		@(posedge clk);
		sleep_request <= 1'b0;
		wait_cyc(3);
		check("idle_halt", {30'h0, core_halt, deep_stop_mode}, 32'h2);
		@(posedge clk);
		wake_request <= 1'b1;
		@(posedge clk);
		wake_request <= 1'b0;
		wait_cyc(3);
		check("idle_wake", {31'h0, core_halt}, 32'h0);
		// Deep stop: clocks halt, exit restores the internal oscillator
		wr(8'h0c, 32'h1);
		@(posedge clk);
		sleep_request <= 1'b1;
		@(posedge clk);
		sleep_request <= 1'b0;
		wait_cyc(3);
		check("deep_halt", {30'h0, core_halt, deep_stop_mode}, 32'h3);
		count_en(3, 20);
		check("deep_no_clk", c, 0);
		@(posedge clk);
		wake_request <= 1'b1;
		@(posedge clk);
		wake_request <= 1'b0;
		wait_cyc(4);
		check("exit_osc_ctrl", {27'h0, osc_ctrl}, 32'h0);
		check("exit_mca", {31'h0, multiplied_clock_active}, 32'h0);
		rd(8'h04);
		check("exit_mul", q, {16'h0, 15'h609f, 1'b0});
		rd(8'h00);
		check("exit_dur_kept", q, osc_word(dur, 7'h00));
		end_of_test();
	end
endmodule : tb_warmup_pll_clock_gear_control
`default_nettype wire

// file: verification/wpcg_osc_model.sv
// External oscillator tick source that feeds the warm-up count pin
`timescale 1ns/1ps
`default_nettype none
module wpcg_osc_model (
	input wire logic clk,
	input wire logic run,
	input wire logic [3:0] half_period,
	output logic tick
);
	logic [3:0] cnt;
	// Start quiet so the pin never floats
	initial begin
		tick = 1'b0;
		cnt = 4'h0;
	end
	// Toggle while running; the pin rests low when the source is stopped
	always @(posedge clk) begin
		if (!run) begin
			tick <= 1'b0;
			cnt <= 4'h0;
		end else if (cnt + 4'h1 >= half_period) begin
			tick <= ~tick;
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : wpcg_osc_model
`default_nettype wire
